// File: verilog/semon_top.sv
/*
 * status and event monitor: vital conditioning, status pin routing,
 * interrupt combine and the latched and real-time interrupt registers.
 * assumes every input is synchronous to i_clk; read strobes are one-cycle
 * pulses marking the end of a completed register read.
 */
`timescale 1ns/1ps

module semon_top #(
    parameter int SLIP_LIMIT = semon_pkg::SLIP_LIMIT_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pri_diff,
    input wire logic [1:0] i_pri_level,
    input wire logic i_pri_rise_slow,
    input wire logic i_pri_fall_slow,
    input wire logic i_sec_diff,
    input wire logic [1:0] i_sec_level,
    input wire logic i_sec_rise_slow,
    input wire logic i_sec_fall_slow,
    input wire logic [7:0] i_ref_monitor_cfg,
    input wire logic i_slip,
    input wire logic i_relock,
    input wire logic i_rdiv_tick,
    input wire logic i_ndiv_tick,
    input wire logic i_mdiv_tick,
    input wire logic i_cal_active,
    input wire logic i_mem_active,
    input wire logic i_auto_switch,
    input wire logic [3:0] i_select_zero,
    input wire logic [3:0] i_select_one,
    input wire logic [1:0] i_polarity,
    input wire logic [1:0] i_clock_mode,
    input wire logic [1:0] i_clock_mute,
    input wire logic [1:0] i_pin_clock,
    input wire logic i_irq_enable,
    input wire logic i_irq_combine_and,
    input wire logic [2:0] i_irq_cfg,
    input wire logic i_irq_cfg_bit0,
    input wire logic [semon_pkg::NUM_SRC-1:0] i_irq_mask,
    input wire logic i_latched_rd,
    input wire logic i_realtime_rd,
    output logic o_status_pin_zero,
    output logic o_status_pin_one,
    output logic o_irq_out,
    output logic o_primary_ref_lost,
    output logic o_secondary_ref_lost,
    output logic o_lock_lost,
    output logic [semon_pkg::NUM_SEL-1:0] o_vitals,
    output logic [semon_pkg::NUM_SRC-1:0] o_latched_irq_reg,
    output logic [semon_pkg::NUM_SRC-1:0] o_realtime_irq_reg
);
    localparam logic [7:0] LIMIT = 8'(SLIP_LIMIT);

    // ----------------------------------------------------------------
    // reference quality check
    // ----------------------------------------------------------------
    function automatic logic ref_fails(input logic diff, input logic [1:0] level,
                                       input logic [1:0] thr, input logic [1:0] edges,
                                       input logic rise_slow, input logic fall_slow);
        logic slow;
        slow = ((edges == semon_pkg::EDGE_RISE) && rise_slow)
            || ((edges == semon_pkg::EDGE_FALL) && fall_slow)
            || ((edges == semon_pkg::EDGE_BOTH) && (rise_slow || fall_slow));
        ref_fails = (level < thr) || (!diff && slow);
    endfunction

    logic [7:0] slip_count;
    logic rdiv_half;
    logic ndiv_half;
    logic mdiv_half;
    logic [semon_pkg::NUM_SRC-1:0] src_prev;
    logic [semon_pkg::NUM_SRC-1:0] src_now;
    logic [semon_pkg::NUM_SEL-1:0] vitals;
    logic combined;
    logic irq_routed;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_primary_ref_lost <= 1'b0;
            o_secondary_ref_lost <= 1'b0;
        end else begin
            o_primary_ref_lost <= ref_fails(i_pri_diff, i_pri_level,
                i_ref_monitor_cfg[semon_pkg::PRI_THR_LSB +: 2],
                i_ref_monitor_cfg[semon_pkg::PRI_EDGE_LSB +: 2],
                i_pri_rise_slow, i_pri_fall_slow);
            o_secondary_ref_lost <= ref_fails(i_sec_diff, i_sec_level,
                i_ref_monitor_cfg[semon_pkg::SEC_THR_LSB +: 2],
                i_ref_monitor_cfg[semon_pkg::SEC_EDGE_LSB +: 2],
                i_sec_rise_slow, i_sec_fall_slow);
        end
    end

    // ----------------------------------------------------------------
    // lock detector
    // ----------------------------------------------------------------
    // lost lock stays flagged until the loop reports relock
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            slip_count <= 8'h00;
            o_lock_lost <= 1'b0;
        end else if (i_slip) begin
            if (slip_count == LIMIT) begin
                slip_count <= 8'h00;
                o_lock_lost <= 1'b1;
            end else begin
                slip_count <= slip_count + 8'h01;
            end
        end else if (i_relock) begin
            o_lock_lost <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // divider monitors
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdiv_half <= 1'b0;
            ndiv_half <= 1'b0;
            mdiv_half <= 1'b0;
        end else begin
            rdiv_half <= rdiv_half ^ i_rdiv_tick;
            ndiv_half <= ndiv_half ^ i_ndiv_tick;
            mdiv_half <= mdiv_half ^ i_mdiv_tick;
        end
    end

    // ----------------------------------------------------------------
    // vital vector and interrupt combine
    // ----------------------------------------------------------------
    assign src_now = {i_auto_switch, i_mem_active, i_cal_active,
                      o_lock_lost, o_secondary_ref_lost, o_primary_ref_lost};
    // masked sources are forced neutral for either combine mode
    assign combined = i_irq_combine_and
        ? &(o_latched_irq_reg | i_irq_mask)
        : |(o_latched_irq_reg & ~i_irq_mask);
    // the pin carries the interrupt only in the documented configuration
    assign irq_routed = o_irq_out && (i_irq_cfg == semon_pkg::IRQ_CFG_ON)
        && i_irq_cfg_bit0;

    always_comb begin
        vitals = '0; // reserved codes read zero
        vitals[semon_pkg::SEL_PRI_LOST] = o_primary_ref_lost;
        vitals[semon_pkg::SEL_SEC_LOST] = o_secondary_ref_lost;
        vitals[semon_pkg::SEL_LOCK_LOST] = o_lock_lost;
        vitals[semon_pkg::SEL_RDIV_HALF] = rdiv_half;
        vitals[semon_pkg::SEL_NDIV_HALF] = ndiv_half;
        vitals[semon_pkg::SEL_CAL_ACTIVE] = i_cal_active;
        vitals[semon_pkg::SEL_IRQ] = irq_routed;
        vitals[semon_pkg::SEL_MDIV_HALF] = mdiv_half;
        vitals[semon_pkg::SEL_MEM_ACTIVE] = i_mem_active;
        vitals[semon_pkg::SEL_AUTO_SWITCH] = i_auto_switch;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_irq_out <= 1'b0;
            o_vitals <= '0;
        end else begin
            o_irq_out <= i_irq_enable && combined;
            o_vitals <= vitals;
        end
    end

    // ----------------------------------------------------------------
    // interrupt registers
    // ----------------------------------------------------------------
    // no write path exists, so the flags change only by events and reads
    // new events win over the read clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            src_prev <= semon_pkg::IRQ_REG_RESET;
            o_latched_irq_reg <= semon_pkg::IRQ_REG_RESET;
            o_realtime_irq_reg <= semon_pkg::IRQ_REG_RESET;
        end else begin
            src_prev <= src_now;
            o_latched_irq_reg <= (i_latched_rd ? semon_pkg::IRQ_REG_RESET : o_latched_irq_reg)
                | ({semon_pkg::NUM_SRC{i_irq_enable}} & src_now & ~src_prev);
            o_realtime_irq_reg <= (i_realtime_rd ? semon_pkg::IRQ_REG_RESET
                : o_realtime_irq_reg) | src_now;
        end
    end

    // ----------------------------------------------------------------
    // status pins
    // ----------------------------------------------------------------
    function automatic logic pin_value(input logic clock_mode, input logic mute,
                                       input logic pol, input logic clk_in,
                                       input logic vital);
        if (clock_mode) begin
            pin_value = (mute && o_lock_lost) ? pol : clk_in;
        end else begin
            pin_value = vital ^ pol;
        end
    endfunction

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_status_pin_zero <= 1'b0;
            o_status_pin_one <= 1'b0;
        end else begin
            o_status_pin_zero <= pin_value(i_clock_mode[0], i_clock_mute[0], i_polarity[0],
                i_pin_clock[0], vitals[i_select_zero]);
            o_status_pin_one <= pin_value(i_clock_mode[1], i_clock_mute[1], i_polarity[1],
                i_pin_clock[1], vitals[i_select_one]);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    pin_select_a: assert property (!i_clock_mode[1] && i_select_one == semon_pkg::SEL_LOCK_LOST
        |=> o_status_pin_one == ($past(o_lock_lost) ^ $past(i_polarity[1])))
        else $error("status pin one does not follow lock loss");
    pin_polarity_a: assert property (!i_clock_mode[0] && i_select_zero == 4'h5 && i_polarity[0]
        |=> o_status_pin_zero) else $error("reserved code not inverted to high");
    mute_hold_a: assert property (i_clock_mode[1] && i_clock_mute[1] && o_lock_lost
        |=> o_status_pin_one == $past(i_polarity[1]))
        else $error("muted pin not static on unlock");
    irq_or_a: assert property (i_irq_enable && !i_irq_combine_and
        && |(o_latched_irq_reg & ~i_irq_mask) |=> o_irq_out)
        else $error("or combine missed a source");
    irq_mask_a: assert property (!i_irq_combine_and && (o_latched_irq_reg & ~i_irq_mask) == '0
        |=> !o_irq_out) else $error("masked sources raised interrupt");
    latch_hold_a: assert property (!i_latched_rd
        |=> (o_latched_irq_reg & $past(o_latched_irq_reg)) == $past(o_latched_irq_reg))
        else $error("latched flag lost without read");
    latch_clear_a: assert property (i_latched_rd && !i_irq_enable |=> o_latched_irq_reg == '0)
        else $error("latched register not cleared by read");
    realtime_a: assert property (!i_irq_enable && o_lock_lost
        |=> o_realtime_irq_reg[semon_pkg::SRC_LOCK_LOST])
        else $error("real-time flag depends on enable");
    lock_slip_a: assert property (i_slip && slip_count == LIMIT
        |=> o_lock_lost && slip_count == 8'h00) else $error("slip limit not honoured");
    los_diff_a: assert property (i_pri_diff && i_pri_level < i_ref_monitor_cfg[1:0]
        |=> o_primary_ref_lost) else $error("primary loss not flagged");

    lock_loss_c: cover property (i_slip && slip_count == LIMIT ##1 o_lock_lost);
    irq_pin_c: cover property (irq_routed ##1 o_status_pin_zero);
    latch_read_c: cover property (o_latched_irq_reg != '0 ##1 i_latched_rd);
    mute_c: cover property (i_clock_mode[1] && i_clock_mute[1] && o_lock_lost);
endmodule

// File: verilog/semon_pkg.sv
/*
 * constants for the status and event monitor: selection codes, source bit
 * positions, configuration field positions and reset values.
 * assumes nothing of its surroundings.
 */
package semon_pkg;
    // ----------------------------------------------------------------
    // status pin selection codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_PRI_LOST = 4'h0;
    localparam logic [3:0] SEL_SEC_LOST = 4'h1;
    localparam logic [3:0] SEL_LOCK_LOST = 4'h2;
    localparam logic [3:0] SEL_RDIV_HALF = 4'h3;
    localparam logic [3:0] SEL_NDIV_HALF = 4'h4;
    localparam logic [3:0] SEL_CAL_ACTIVE = 4'h8;
    localparam logic [3:0] SEL_IRQ = 4'hA;
    localparam logic [3:0] SEL_MDIV_HALF = 4'hB;
    localparam logic [3:0] SEL_MEM_ACTIVE = 4'hD;
    localparam logic [3:0] SEL_AUTO_SWITCH = 4'hE;
    localparam int NUM_SEL = 16;

    // ----------------------------------------------------------------
    // interrupt source bit positions
    // ----------------------------------------------------------------
    localparam int NUM_SRC = 6;
    localparam int SRC_PRI_LOST = 0;
    localparam int SRC_SEC_LOST = 1;
    localparam int SRC_LOCK_LOST = 2;
    localparam int SRC_CAL = 3;
    localparam int SRC_MEM = 4;
    localparam int SRC_AUTO = 5;

    // ----------------------------------------------------------------
    // interrupt configuration and monitor fields
    // ----------------------------------------------------------------
    localparam logic [2:0] IRQ_CFG_ON = 3'h7;
    localparam int PRI_THR_LSB = 0;
    localparam int SEC_THR_LSB = 2;
    localparam int PRI_EDGE_LSB = 4;
    localparam int SEC_EDGE_LSB = 6;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ----------------------------------------------------------------
    // reset values and default slip limit
    // ----------------------------------------------------------------
    localparam logic [NUM_SRC-1:0] IRQ_REG_RESET = 6'h00;
    localparam int SLIP_LIMIT_DEFAULT = 8;
endpackage

// File: test/semon_tb.sv
/*
 * self-checking bench for the status and event monitor top.
 * assumes the block takes every input on the rising edge and answers in
 * the fixed cycle counts of its hand-over; no other module is needed.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    // short slip limit keeps the lock scenario brief
    localparam int LIM = 2;
    logic i_clk = 0, i_reset = 1;
    logic i_pri_diff = 0, i_pri_rise_slow = 0, i_pri_fall_slow = 0, i_sec_diff = 0;
    logic i_sec_rise_slow = 0, i_sec_fall_slow = 0, i_slip = 0, i_relock = 0;
    logic i_rdiv_tick = 0, i_ndiv_tick = 0, i_mdiv_tick = 0, i_cal_active = 0;
    logic i_mem_active = 0, i_auto_switch = 0, i_irq_enable = 0, i_irq_combine_and = 0;
    logic i_irq_cfg_bit0 = 0, i_latched_rd = 0, i_realtime_rd = 0;
    logic [1:0] i_pri_level = 0, i_sec_level = 0, i_polarity = 0, i_clock_mode = 0;
    logic [1:0] i_clock_mute = 0, i_pin_clock = 0;
    logic [2:0] i_irq_cfg = 0;
    logic [3:0] i_select_zero = 0, i_select_one = 0;
    logic [7:0] i_ref_monitor_cfg = 0, m;
    logic [semon_pkg::NUM_SRC-1:0] i_irq_mask = 0, o_latched_irq_reg, o_realtime_irq_reg;
    logic [semon_pkg::NUM_SEL-1:0] o_vitals;
    logic o_status_pin_zero, o_status_pin_one, o_irq_out;
    logic o_primary_ref_lost, o_secondary_ref_lost, o_lock_lost;
    logic ep, es;
    int fails = 0, total_checks = 0;

    always #2 i_clk = ~i_clk;

    semon_top #(.SLIP_LIMIT(LIM)) i_dut (.i_clk, .i_reset, .i_pri_diff, .i_pri_level,
        .i_pri_rise_slow, .i_pri_fall_slow, .i_sec_diff, .i_sec_level, .i_sec_rise_slow,
        .i_sec_fall_slow, .i_ref_monitor_cfg, .i_slip, .i_relock, .i_rdiv_tick,
        .i_ndiv_tick, .i_mdiv_tick, .i_cal_active, .i_mem_active, .i_auto_switch,
        .i_select_zero, .i_select_one, .i_polarity, .i_clock_mode, .i_clock_mute,
        .i_pin_clock, .i_irq_enable, .i_irq_combine_and, .i_irq_cfg, .i_irq_cfg_bit0,
        .i_irq_mask, .i_latched_rd, .i_realtime_rd, .o_status_pin_zero,
        .o_status_pin_one, .o_irq_out, .o_primary_ref_lost, .o_secondary_ref_lost,
        .o_lock_lost, .o_vitals, .o_latched_irq_reg, .o_realtime_irq_reg);

    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic lost(input logic dif, input logic [1:0] lvl, thr, edg,
                                  input logic rs, fs);
        return (lvl < thr) || (!dif && ((edg[0] && rs) || (edg[1] && fs)));
    endfunction

    // only the level vitals vary while routing is checked; the rest stay 0
    function automatic logic vit(input logic [3:0] c);
        case (c)
            semon_pkg::SEL_CAL_ACTIVE: return i_cal_active;
            semon_pkg::SEL_MEM_ACTIVE: return i_mem_active;
            semon_pkg::SEL_AUTO_SWITCH: return i_auto_switch;
            default: return 1'b0;
        endcase
    endfunction

    // sample one step after the edge so its updates have landed
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic rd(input bit lat);
        if (lat) i_latched_rd <= 1;
        else i_realtime_rd <= 1;
        wt(1);
        i_latched_rd <= 0;
        i_realtime_rd <= 0;
        wt(2);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(73));
        wt(20);
        i_reset <= 0;
        wt(1);
        `CHK("vitals", 16'h0000, o_vitals)
        for (int k = 0; k < 32; k++) begin
            {i_cal_active, i_mem_active, i_auto_switch} <= 3'($urandom);
            i_select_zero <= 4'(k);
            i_select_one <= 4'($urandom);
            i_polarity <= 2'($urandom);
            wt(3);
            `CHK("pin zero", vit(i_select_zero) ^ i_polarity[0], o_status_pin_zero)
            `CHK("pin one", vit(i_select_one) ^ i_polarity[1], o_status_pin_one)
            `CHK("cal vital", i_cal_active, o_vitals[semon_pkg::SEL_CAL_ACTIVE])
        end
        for (int k = 0; k < 40; k++) begin
            {i_pri_diff, i_sec_diff, i_pri_rise_slow, i_pri_fall_slow, i_sec_rise_slow,
                i_sec_fall_slow} <= 6'($urandom);
            {i_pri_level, i_sec_level} <= 4'($urandom);
            i_ref_monitor_cfg <= 8'($urandom);
            wt(2);
            m = i_ref_monitor_cfg;
            ep = lost(i_pri_diff, i_pri_level, m[1:0], m[5:4], i_pri_rise_slow,
                i_pri_fall_slow);
            es = lost(i_sec_diff, i_sec_level, m[3:2], m[7:6], i_sec_rise_slow,
                i_sec_fall_slow);
            `CHK("pri lost", ep, o_primary_ref_lost)
            `CHK("sec lost", es, o_secondary_ref_lost)
            `CHK("pri vital", ep, o_vitals[semon_pkg::SEL_PRI_LOST])
            `CHK("sec vital", es, o_vitals[semon_pkg::SEL_SEC_LOST])
        end
        i_ref_monitor_cfg <= 0;
        {i_cal_active, i_mem_active, i_auto_switch} <= 0;
        for (int j = 0; j < 3; j++) begin
            i_rdiv_tick <= (j == 0);
            i_ndiv_tick <= (j < 2);
            i_mdiv_tick <= 1;
            wt(1);
        end
        {i_rdiv_tick, i_ndiv_tick, i_mdiv_tick} <= 0;
        wt(2);
        `CHK("div monitors", 3'b101, {o_vitals[3], o_vitals[4], o_vitals[11]})
        // second round shows the slip count restarts after a loss
        {i_clock_mode, i_clock_mute, i_polarity, i_pin_clock} <= 8'b1010_1000;
        for (int r = 0; r < 2; r++) begin
            for (int k = 1; k <= LIM + 1; k++) begin
                i_slip <= 1;
                wt(1);
                i_slip <= 0;
                wt(1);
                `CHK("lock lost", logic'(k > LIM), o_lock_lost)
            end
            wt(2);
            `CHK("muted pin", 1'b1, o_status_pin_one)
            i_relock <= 1;
            wt(1);
            i_relock <= 0;
            wt(1);
            `CHK("relocked", 1'b0, o_lock_lost)
        end
        rd(1);
        rd(0);
        i_irq_enable <= 1;
        i_irq_cfg <= semon_pkg::IRQ_CFG_ON;
        i_irq_cfg_bit0 <= 1;
        i_select_zero <= semon_pkg::SEL_IRQ;
        i_polarity <= 0;
        i_cal_active <= 1;
        wt(4);
        `CHK("latched", 6'h08, o_latched_irq_reg)
        `CHK("realtime", 6'h08, o_realtime_irq_reg)
        `CHK("irq or", 1'b1, o_irq_out)
        `CHK("irq pin", 1'b1, o_status_pin_zero)
        i_cal_active <= 0;
        rd(0);
        `CHK("realtime read", 6'h00, o_realtime_irq_reg)
        `CHK("latched held", 6'h08, o_latched_irq_reg)
        rd(1);
        `CHK("latched read", 6'h00, o_latched_irq_reg)
        `CHK("irq cleared", 1'b0, o_irq_out)
        i_irq_mask <= 6'h08;
        i_cal_active <= 1;
        wt(4);
        `CHK("irq masked", 1'b0, o_irq_out)
        i_cal_active <= 0;
        rd(1);
        i_irq_combine_and <= 1;
        i_irq_mask <= 6'h27;
        i_cal_active <= 1;
        wt(4);
        `CHK("irq and one", 1'b0, o_irq_out)
        i_mem_active <= 1;
        wt(4);
        `CHK("irq and both", 1'b1, o_irq_out)
        {i_cal_active, i_mem_active, i_irq_enable, i_irq_combine_and} <= 0;
        i_irq_mask <= 0;
        rd(1);
        rd(0);
        i_auto_switch <= 1;
        wt(3);
        `CHK("latched off", 6'h00, o_latched_irq_reg)
        `CHK("realtime off", 6'h20, o_realtime_irq_reg)
        give_verdict();
    end
endmodule
